// ===== logic/ppe_pkg.sv
package ppe_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int N_OUT = 3;
  localparam int N_CAP = 2;
  localparam int N_PIN = 2;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_UNIT_SEL = 12'h520;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h528;
  localparam logic [ADDR_W-1:0] OFF_UNIT_CTRL = 12'h52c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h5f0;

  // ---------------------------------------------------------------
  // Unit select fields
  // ---------------------------------------------------------------
  localparam int SEL_OUT_LSB = 0;
  localparam int SEL_CAP_BIT = 8;
  localparam int SEL_PIN_BIT = 16;
  localparam logic [31:0] SEL_WMASK = 32'h000f_0f03;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [1:0] OUT_SEL_RSVD = 2'h3;

  // ---------------------------------------------------------------
  // Interrupt status and mask fields
  // ---------------------------------------------------------------
  localparam int STAT_OUT_LSB = 16;
  localparam int STAT_CAP_LSB = 0;

  // ---------------------------------------------------------------
  // Unit control fields
  // ---------------------------------------------------------------
  localparam int CTL_COMB_SEL = 8;
  localparam int CTL_PIN_LEVEL = 7;
  localparam int CTL_PIN_DIR = 6;
  localparam int CTL_CAP_IRQ_EN = 5;
  localparam int CTL_ACTIVE = 4;
  localparam int CTL_ARM = 3;
  localparam int CTL_SOFT_CLEAR = 2;

  typedef struct packed {
    logic [N_OUT-1:0] out;
    logic [N_CAP-1:0] cap;
  } ppe_irq_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_RESP
  } ppe_bus_st_t;

endpackage

// ===== logic/ppe_ctrl.sv
// What this block does
// - Summary interrupt output is the OR of all status bits.
// - Output unit status bits sit at 18:16, one per unit.
// - Output unit status sets only when its completion notify enable is on.
// - Capture unit status bits sit at 1:0, one per unit.
// - Capture status sets only while that unit's control bit 5 is 1.
// - Status bits reset to 0, read 1 on event, software clears them.
// - Control fields are routed by unit select bits 1:0, 8 and 16.
// - Control bit 8 picks combinational or flopped pin output, reset flopped.
// - Control bit 7 shows the selected pin's present input level.
// - Control bit 6 set makes the pin a capture input, else output.
// - Control bit 4 reads 1 while the output unit runs without error.
// - Writing bit 3 arms the unit; it self-clears when the event fires.
// - Writing 1 to bit 2 returns the selected output unit to defaults.
// - An output unit's late error clears whenever its arm bit clears.
// - Output select 00, 01, 10 pick units 0..2; 11 is reserved.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ppe_ctrl
  import ppe_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [N_OUT-1:0] completion_notify_enable_i,
  input wire logic [N_OUT-1:0] out_event_done_i,
  input wire logic [N_OUT-1:0] out_event_late_i,
  input wire logic [N_CAP-1:0] capture_event_i,
  input wire logic [N_PIN-1:0] pin_level_i,
  output logic [N_PIN-1:0] pin_direction_select_o,
  output logic [N_PIN-1:0] pin_comb_out_sel_o,
  output logic [N_OUT-1:0] out_arm_o,
  output logic [N_OUT-1:0] out_active_o,
  output logic [N_OUT-1:0] event_unit_soft_clear_o,
  output logic irq_summary_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  logic [N_PIN-1:0] pin_lvl_q;

  for (genvar p = 0; p < N_PIN; p++) begin : g_sync
    logic [2:0] sync_q;
    logic lvl_d;
    always_comb begin
      lvl_d = pin_lvl_q[p];
      if (sync_q[1] == sync_q[2]) begin
        lvl_d = sync_q[2];
      end
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sync_q <= 3'h0;
        pin_lvl_q[p] <= 1'b0;
      end else begin
        sync_q <= {sync_q[1:0], pin_level_i[p]};
        pin_lvl_q[p] <= lvl_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus slave and register state
  // ---------------------------------------------------------------
  ppe_bus_st_t st_q, st_d;
  logic [31:0] sel_q, sel_d;
  ppe_irq_t stat_q, stat_d, mask_q, mask_d;
  logic [N_OUT-1:0] arm_q, arm_d, err_q, err_d, act_q, act_d, sclr_q, sclr_d;
  logic [N_CAP-1:0] cap_en_q, cap_en_d;
  logic [N_PIN-1:0] dir_q, dir_d, comb_q, comb_d;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q, slverr_d, ready_q, ready_d;
  logic summ_q, summ_d, irq_q, irq_d;
  logic commit, wr, rd, ctl_wr;
  logic [1:0] osel;
  logic csel, psel_pin;
  ppe_irq_t set_v, clr_v;

  assign osel = sel_q[SEL_OUT_LSB +: 2];
  assign csel = sel_q[SEL_CAP_BIT];
  assign psel_pin = sel_q[SEL_PIN_BIT];
  // A write or read-clear takes effect only on the edge that ends the access.
  assign commit = (st_q == BUS_RESP) && psel_i && penable_i;
  assign wr = commit && pwrite_i;
  assign rd = commit && !pwrite_i;
  assign ctl_wr = wr && (paddr_i == OFF_UNIT_CTRL);

  always_comb begin
    st_d = st_q;
    ready_d = 1'b0;
    rdata_d = rdata_q;
    slverr_d = 1'b0;
    if (st_q == BUS_IDLE) begin
      if (psel_i && penable_i) begin
        st_d = BUS_RESP;
        ready_d = 1'b1;
        rdata_d = 32'h0000_0000;
        if (paddr_i == OFF_UNIT_SEL) begin
          rdata_d = sel_q;
        end else if (paddr_i == OFF_IRQ_STATUS) begin
          rdata_d[STAT_OUT_LSB +: N_OUT] = stat_q.out;
          rdata_d[STAT_CAP_LSB +: N_CAP] = stat_q.cap;
        end else if (paddr_i == OFF_IRQ_MASK) begin
          rdata_d[STAT_OUT_LSB +: N_OUT] = mask_q.out;
          rdata_d[STAT_CAP_LSB +: N_CAP] = mask_q.cap;
        end else if (paddr_i == OFF_UNIT_CTRL) begin
          rdata_d[CTL_COMB_SEL] = comb_q[psel_pin];
          rdata_d[CTL_PIN_LEVEL] = pin_lvl_q[psel_pin];
          rdata_d[CTL_PIN_DIR] = dir_q[psel_pin];
          rdata_d[CTL_CAP_IRQ_EN] = cap_en_q[csel];
          if (osel != OUT_SEL_RSVD) begin
            rdata_d[CTL_ACTIVE] = act_q[osel];
            rdata_d[CTL_ARM] = arm_q[osel];
          end
        end else begin
          slverr_d = 1'b1;
        end
      end
    end else begin
      st_d = BUS_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Control fields, output units and interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    sel_d = sel_q;
    mask_d = mask_q;
    dir_d = dir_q;
    comb_d = comb_q;
    cap_en_d = cap_en_q;
    arm_d = arm_q;
    err_d = err_q;
    sclr_d = '0;
    set_v = '0;
    clr_v = '0;
    if (wr && (paddr_i == OFF_UNIT_SEL)) begin
      sel_d = pwdata_i & SEL_WMASK;
    end
    if (wr && (paddr_i == OFF_IRQ_MASK)) begin
      mask_d.out = pwdata_i[STAT_OUT_LSB +: N_OUT];
      mask_d.cap = pwdata_i[STAT_CAP_LSB +: N_CAP];
    end
    if (ctl_wr) begin
      dir_d[psel_pin] = pwdata_i[CTL_PIN_DIR];
      comb_d[psel_pin] = pwdata_i[CTL_COMB_SEL];
      cap_en_d[csel] = pwdata_i[CTL_CAP_IRQ_EN];
    end
    for (int i = 0; i < N_OUT; i++) begin
      if (out_event_done_i[i] && arm_q[i]) begin
        arm_d[i] = 1'b0;
      end
      if (ctl_wr && (osel == i[1:0])) begin
        arm_d[i] = pwdata_i[CTL_ARM];
        if (pwdata_i[CTL_SOFT_CLEAR]) begin
          arm_d[i] = 1'b0;
          sclr_d[i] = 1'b1;
        end
      end
      err_d[i] = arm_d[i] && (err_q[i] || (arm_q[i] && out_event_late_i[i]));
      set_v.out[i] = arm_q[i] && (out_event_done_i[i] || out_event_late_i[i])
                     && completion_notify_enable_i[i];
    end
    set_v.cap = capture_event_i & cap_en_q;
    if (rd && (paddr_i == OFF_IRQ_STATUS)) begin
      // Only the bits returned by this read are cleared, so an event that lands
      // between the data capture and the end of the access is kept.
      clr_v.out = rdata_q[STAT_OUT_LSB +: N_OUT];
      clr_v.cap = rdata_q[STAT_CAP_LSB +: N_CAP];
    end else if (wr && (paddr_i == OFF_IRQ_STATUS)) begin
      clr_v.out = pwdata_i[STAT_OUT_LSB +: N_OUT];
      clr_v.cap = pwdata_i[STAT_CAP_LSB +: N_CAP];
    end
    // A new event in the clearing cycle keeps its bit set.
    stat_d = set_v | (stat_q & ~clr_v);
    act_d = arm_d & ~err_d;
    summ_d = |stat_d;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= BUS_IDLE;
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      sel_q <= SEL_RESET;
      mask_q <= '0;
      stat_q <= '0;
      dir_q <= '0;
      comb_q <= '0;
      cap_en_q <= '0;
      arm_q <= '0;
      err_q <= '0;
      act_q <= '0;
      sclr_q <= '0;
      summ_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
      sel_q <= sel_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      dir_q <= dir_d;
      comb_q <= comb_d;
      cap_en_q <= cap_en_d;
      arm_q <= arm_d;
      err_q <= err_d;
      act_q <= act_d;
      sclr_q <= sclr_d;
      summ_q <= summ_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = ready_q;
  assign pslverr_o = slverr_q;
  assign pin_direction_select_o = dir_q;
  assign pin_comb_out_sel_o = comb_q;
  assign out_arm_o = arm_q;
  assign out_active_o = act_q;
  assign event_unit_soft_clear_o = sclr_q;
  assign irq_summary_o = summ_q;
  assign irq_o = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_ctl_read_unit1;
    (st_q == BUS_IDLE) && psel_i && penable_i && !pwrite_i
      && (paddr_i == OFF_UNIT_CTRL) && (osel == 2'h1);
  endsequence

  sequence s_status_read_quiet;
    rd && (paddr_i == OFF_IRQ_STATUS) && (out_event_done_i == '0)
      && (out_event_late_i == '0) && (capture_event_i == '0)
      && (rdata_q[STAT_OUT_LSB +: N_OUT] == stat_q.out)
      && (rdata_q[STAT_CAP_LSB +: N_CAP] == stat_q.cap);
  endsequence

  property p_summary_or;
    @(posedge clock_i) disable iff (!arst_n_i)
      ##1 irq_summary_o == (|stat_q);
  endproperty
  a_summary_or: assert property (p_summary_or) else $error("summary not OR of status");

  property p_out_needs_notify;
    @(posedge clock_i) disable iff (!arst_n_i)
      $rose(stat_q.out[1]) |-> $past(completion_notify_enable_i[1]) && $past(arm_q[1]);
  endproperty
  a_out_needs_notify: assert property (p_out_needs_notify) else $error("output irq without notify");

  property p_cap_needs_enable;
    @(posedge clock_i) disable iff (!arst_n_i)
      $rose(stat_q.cap[0]) |-> $past(cap_en_q[0]) && $past(capture_event_i[0]);
  endproperty
  a_cap_needs_enable: assert property (p_cap_needs_enable) else $error("capture irq while disabled");

  property p_read_clears;
    @(posedge clock_i) disable iff (!arst_n_i)
      s_status_read_quiet |=> (stat_q == '0) && !irq_summary_o;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  property p_set_wins;
    @(posedge clock_i) disable iff (!arst_n_i)
      wr && (paddr_i == OFF_IRQ_STATUS) && capture_event_i[1] && cap_en_q[1]
        |=> stat_q.cap[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost during clear");

  property p_ctl_read_routed;
    @(posedge clock_i) disable iff (!arst_n_i)
      s_ctl_read_unit1 |=> pready_o && (prdata_o[CTL_ARM] == $past(arm_q[1]))
        && (prdata_o[CTL_PIN_LEVEL] == $past(pin_lvl_q[psel_pin]));
  endproperty
  a_ctl_read_routed: assert property (p_ctl_read_routed) else $error("control read misrouted");

  property p_arm_self_clear;
    @(posedge clock_i) disable iff (!arst_n_i)
      arm_q[0] && out_event_done_i[0] && !ctl_wr |=> !arm_q[0] ##1 !out_active_o[0];
  endproperty
  a_arm_self_clear: assert property (p_arm_self_clear) else $error("arm not self-cleared");

  property p_soft_clear;
    @(posedge clock_i) disable iff (!arst_n_i)
      ctl_wr && (osel == 2'h2) && pwdata_i[CTL_SOFT_CLEAR]
        |=> !arm_q[2] && !err_q[2] && event_unit_soft_clear_o[2] ##1 !event_unit_soft_clear_o[2];
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft clear failed");

  property p_err_follows_arm;
    @(posedge clock_i) disable iff (!arst_n_i)
      $fell(arm_q[0]) |-> !err_q[0] && !out_active_o[0];
  endproperty
  a_err_follows_arm: assert property (p_err_follows_arm) else $error("late error kept");

  property p_rsvd_select;
    @(posedge clock_i) disable iff (!arst_n_i)
      ctl_wr && (osel == OUT_SEL_RSVD) && (out_event_done_i == '0) |=> $stable(arm_q);
  endproperty
  a_rsvd_select: assert property (p_rsvd_select) else $error("reserved select armed a unit");

  property p_rsvd_zero;
    @(posedge clock_i) disable iff (!arst_n_i)
      pready_o && ($past(paddr_i) == OFF_IRQ_STATUS)
        |-> (prdata_o[31:19] == 13'h0000) && (prdata_o[15:2] == 14'h0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bits nonzero");

endmodule

`default_nettype wire

// ===== dv/ppe_event_model.sv
`timescale 1ns/1ps
`default_nettype none

module ppe_event_model
  import ppe_pkg::*;
(
  input wire logic clock_i,
  output logic [N_OUT-1:0] done_o,
  output logic [N_OUT-1:0] late_o,
  output logic [N_CAP-1:0] cap_o,
  output logic [N_PIN-1:0] pin_o
);
  // ---------------------------------------------------------------
  // Event pulses
  // ---------------------------------------------------------------
  initial begin
    done_o = '0;
    late_o = '0;
    cap_o = '0;
    pin_o = '0;
  end

  // Kind 0 is a finished output event, 1 a late target, 2 a capture.
  task automatic pulse(input int kind, input int unit);
    @(posedge clock_i);
    if (kind == 0) done_o[unit] <= 1'b1;
    else if (kind == 1) late_o[unit] <= 1'b1;
    else cap_o[unit] <= 1'b1;
    @(posedge clock_i);
    done_o <= '0;
    late_o <= '0;
    cap_o <= '0;
  endtask

  task automatic set_pin(input logic [N_PIN-1:0] v);
    @(posedge clock_i);
    pin_o <= v;
  endtask
endmodule

`default_nettype wire

// ===== dv/ppe_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module ppe_ctrl_test
  import ppe_pkg::*;
;
  logic clock_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, q;
  logic pready_o, pslverr_o, irq_summary_o, irq_o, err, sclr_seen = 0;
  logic [N_OUT-1:0] notify = '0, done, late, arm, active, sclr;
  logic [N_CAP-1:0] cap;
  logic [N_PIN-1:0] pin, dir, comb;
  int n_errors = 0, checks_done = 0;

  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) sclr_seen <= sclr_seen | (|sclr);

  ppe_event_model ppe_event_model_inst (.clock_i(clock_i), .done_o(done), .late_o(late),
    .cap_o(cap), .pin_o(pin));

  ppe_ctrl ppe_ctrl_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .completion_notify_enable_i(notify), .out_event_done_i(done), .out_event_late_i(late),
    .capture_event_i(cap), .pin_level_i(pin), .pin_direction_select_o(dir),
    .pin_comb_out_sel_o(comb), .out_arm_o(arm), .out_active_o(active),
    .event_unit_soft_clear_o(sclr), .irq_summary_o(irq_summary_o), .irq_o(irq_o));

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready, data and error are taken at the rising edge that completes the access; the
  // task returns one edge later so that the effect of the access can be seen.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      n_errors++;
      final_report();
    end
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, '0);
    chk(nm, q, e);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_IRQ_STATUS, 32'h0, "status");
    rd(OFF_UNIT_CTRL, 32'h0, "ctrl");
    apb(1'b0, 12'h5fc, '0);
    chk("slverr", 32'(err), 32'h1);
    wr(OFF_UNIT_SEL, 32'hffff_ffff);
    rd(OFF_UNIT_SEL, SEL_WMASK, "sel");
  endtask

  task automatic t_out();
    for (int u = 0; u < N_OUT; u++) begin
      notify <= N_OUT'(1) << u;
      wr(OFF_UNIT_SEL, 32'(u));
      wr(OFF_UNIT_CTRL, 32'h8);
      chk("arm", 32'(arm), 32'h1 << u);
      rd(OFF_UNIT_CTRL, 32'h18, "armed");
      ppe_event_model_inst.pulse(0, u);
      rd(OFF_UNIT_CTRL, 32'h0, "fired");
      chk("summary", 32'(irq_summary_o), 32'h1);
      rd(OFF_IRQ_STATUS, 32'h1 << (16 + u), "ostat");
      rd(OFF_IRQ_STATUS, 32'h0, "oclr");
    end
    notify <= '0;
    wr(OFF_UNIT_CTRL, 32'h8);
    ppe_event_model_inst.pulse(0, 2);
    rd(OFF_IRQ_STATUS, 32'h0, "nonotify");
    chk("summary0", 32'(irq_summary_o), 32'h0);
  endtask

  task automatic t_mask();
    notify <= 3'h1;
    wr(OFF_UNIT_SEL, 32'h0);
    wr(OFF_UNIT_CTRL, 32'h8);
    ppe_event_model_inst.pulse(0, 0);
    wr(OFF_IRQ_MASK, 32'h0);
    chk("masked", 32'(irq_o), 32'h0);
    wr(OFF_IRQ_MASK, 32'h1_0000);
    chk("unmasked", 32'(irq_o), 32'h1);
    wr(OFF_IRQ_STATUS, 32'h1_0000);
    rd(OFF_IRQ_STATUS, 32'h0, "w1clr");
    chk("irqclr", 32'(irq_o), 32'h0);
  endtask

  task automatic t_cap();
    for (int c = 0; c < N_CAP; c++) begin
      wr(OFF_UNIT_SEL, 32'(c) << 8);
      wr(OFF_UNIT_CTRL, 32'h20);
      ppe_event_model_inst.pulse(2, c);
      rd(OFF_IRQ_STATUS, 32'h1 << c, "cstat");
      wr(OFF_UNIT_CTRL, 32'h0);
      ppe_event_model_inst.pulse(2, c);
      rd(OFF_IRQ_STATUS, 32'h0, "cdis");
    end
  endtask

  task automatic t_pin();
    for (int p = 0; p < N_PIN; p++) begin
      ppe_event_model_inst.set_pin(N_PIN'(1) << p);
      wr(OFF_UNIT_SEL, 32'(p) << 16);
      wr(OFF_UNIT_CTRL, 32'h140);
      chk("comb", 32'(comb), 32'h1 << p);
      chk("dir", 32'(dir), 32'h1 << p);
      rd(OFF_UNIT_CTRL, 32'h1c0, "level");
      wr(OFF_UNIT_CTRL, 32'h0);
      chk("pins", 32'({comb, dir}), 32'h0);
    end
  endtask

  task automatic t_soft_late();
    wr(OFF_UNIT_SEL, 32'h2);
    wr(OFF_UNIT_CTRL, 32'h8);
    wr(OFF_UNIT_CTRL, 32'h4);
    chk("sclr", 32'(sclr), 32'h4);
    rd(OFF_UNIT_CTRL, 32'h0, "softclr");
    chk("sclr_once", 32'({sclr_seen, sclr}), 32'h8);
    wr(OFF_UNIT_SEL, 32'h1);
    wr(OFF_UNIT_CTRL, 32'h8);
    notify <= 3'h2;
    ppe_event_model_inst.pulse(1, 1);
    rd(OFF_UNIT_CTRL, 32'h8, "late");
    rd(OFF_IRQ_STATUS, 32'h2_0000, "latestat");
    wr(OFF_UNIT_CTRL, 32'h0);
    wr(OFF_UNIT_CTRL, 32'h8);
    rd(OFF_UNIT_CTRL, 32'h18, "rearm");
    chk("active", 32'(active), 32'h2);
    wr(OFF_UNIT_CTRL, 32'h0);
    wr(OFF_UNIT_SEL, 32'(OUT_SEL_RSVD));
    wr(OFF_UNIT_CTRL, 32'h8);
    chk("rsvdarm", 32'(arm), 32'h0);
    rd(OFF_UNIT_CTRL, 32'h0, "rsvdctl");
  endtask

  task automatic t_midreset();
    wr(OFF_UNIT_SEL, 32'h1_0101);
    wr(OFF_UNIT_CTRL, 32'h168);
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    chk("rstunits", 32'({arm, dir, comb}), 32'h0);
    rd(OFF_UNIT_SEL, 32'h0, "rstsel");
    rd(OFF_UNIT_CTRL, 32'h0, "rstctl");
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_out();
    t_mask();
    t_cap();
    t_pin();
    t_soft_late();
    t_midreset();
    final_report();
  end
endmodule

`default_nettype wire
